// ---- rtl/ceu_consts.svh ----
// Constants of the exception unit: offsets, field positions, vectors,
// mode codes, reset values and entry timing counts.
// Assumes a 32-bit status word and a byte-addressed Wishbone slave.
`ifndef CEU_CONSTS_SVH
`define CEU_CONSTS_SVH
// Mode field codes
`define CEU_MODE_USR 5'h10
`define CEU_MODE_FIQ 5'h11
`define CEU_MODE_IRQ 5'h12
`define CEU_MODE_SVC 5'h13
`define CEU_MODE_ABT 5'h17
`define CEU_MODE_UND 5'h1B
// Status word field positions
`define CEU_PSR_I 7
`define CEU_PSR_F 6
`define CEU_PSR_T 5
// Status word after system reset: supervisor, both masks set
`define CEU_CSW_RST 32'h0000_00D3
// Vector table
`define CEU_VEC_RST 32'h0000_0000
`define CEU_VEC_UND 32'h0000_0004
`define CEU_VEC_TRAP 32'h0000_0008
`define CEU_VEC_PABORT 32'h0000_000C
`define CEU_VEC_DABORT 32'h0000_0010
`define CEU_VEC_RSVD 32'h0000_0014
`define CEU_VEC_IRQ 32'h0000_0018
`define CEU_VEC_FIQ 32'h0000_001C
// Link offsets and fetch step
`define CEU_OFS2 32'h0000_0002
`define CEU_OFS4 32'h0000_0004
`define CEU_OFS8 32'h0000_0008
// Bank index of a mode without saved registers
`define CEU_BANK_NONE 3'h7
// Register offsets
`define CEU_ADR_CSW 8'h00
`define CEU_ADR_SSW 8'h04
`define CEU_ADR_LINK 8'h08
`define CEU_ADR_EXIT 8'h0C
`define CEU_ADR_CAUSE 8'h10
// Entry times in processor cycles
`define CEU_T_EXC_CYC 2'h3
`define CEU_T_FIQ_CYC 2'h2
`define CEU_T_OTH_CYC 2'h2
`endif

// ---- rtl/ceu_pkg.sv ----
// Types shared by the exception unit.
// Assumes nothing of its surroundings.
package ceu_pkg;
  typedef enum logic [1:0] {
    CEU_ST_RUN = 2'h1,
    CEU_ST_ENTRY = 2'h2
  } ceu_state_t;
  typedef enum logic [6:0] {
    CEU_EX_RST = 7'h01,
    CEU_EX_DABORT = 7'h02,
    CEU_EX_FIQ = 7'h04,
    CEU_EX_IRQ = 7'h08,
    CEU_EX_PABORT = 7'h10,
    CEU_EX_UND = 7'h20,
    CEU_EX_TRAP = 7'h40
  } ceu_cause_t;
  typedef enum logic [2:0] {
    CEU_XF_SINGLE = 3'h1,
    CEU_XF_SWAP = 3'h2,
    CEU_XF_BLOCK = 3'h4
  } ceu_xfer_t;
endpackage

// ---- rtl/ceu_exception_unit.sv ----
// Exception unit of a 32-bit core: interrupt sync, abort tracking,
// priority, entry sequencing, banked link and saved status words.
// Assumes the core pulses INSN_END at each instruction end and obeys
// REG_WR_BLOCK and BASE_WB_EN; one clock, Wishbone classic slave.
//
// Notes on behaviour
// (RULE_01) Entry writes adjusted next-instruction address into entered mode's link.
// (RULE_02) Entry saves status word, forces mode, fetches from the vector.
// (RULE_03) Entry may set mask flags to stop uncontrolled nesting.
// (RULE_04) Entry from compressed state returns to full-width state.
// (RULE_05) Exit restores saved status, bringing back the state flag.
// (RULE_06) Full-width link is address plus 4, data abort plus 8.
// (RULE_07) Supervisor link saved by reset is meaningless.
// (RULE_08) Fast request is active low; sync select low adds synchroniser.
// (RULE_09) Fast request sampled at each instruction end while unmasked.
// (RULE_10) Normal interrupt ranks below fast; fast entry masks normal.
// (RULE_11) Mask flags change only in privileged modes.
// (RULE_12) Abort input is checked during memory access cycles.
// (RULE_13) Prefetch abort tags the instruction; taken only at pipeline head.
// (RULE_14) Aborted single transfer writes base back; swap acts unexecuted.
// (RULE_15) Aborted block transfer completes; later register overwrites blocked.
// (RULE_16) Fixed vector table with its entry modes.
// (RULE_17) Fixed priority: reset, data abort, fast, normal, prefetch, traps.
// (RULE_18) Data abort with fast interrupt: abort entry, then fast entry.
// (RULE_19) Sync at most 3 cycles; abort entry 3, fast entry 2.
// (RULE_20) While reset is low, fetch from incrementing word addresses.
// (RULE_21) Reset release copies program counter and status to supervisor bank.
// (RULE_22) Reset release: supervisor mode, masks set, state clear, fetch 0.
// (RULE_23) Sync select high samples the requests directly.
// (RULE_24) Reserved vector is never generated.
`timescale 1ns/1ps
`default_nettype none
`include "ceu_consts.svh"
module ceu_exception_unit
  import ceu_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RESET_LOW_IN,
  input wire logic FAST_REQUEST_LOW_IN,
  input wire logic NORMAL_REQUEST_LOW_IN,
  input wire logic INTERRUPT_SYNC_SELECT,
  input wire logic ABORT_IN,
  input wire logic MEM_CYCLE,
  input wire logic MEM_DATA,
  input wire logic FETCH_ADVANCE,
  input wire logic PIPE_FLUSH,
  input wire logic INSN_END,
  input wire logic [31:0] INSN_PC,
  input wire logic INSN_UNDEF,
  input wire logic INSN_TRAP,
  input wire logic [2:0] XFER_KIND,
  input wire logic XFER_WB,
  output logic [31:0] VECTOR_ADDR,
  output logic VECTOR_LOAD,
  output logic [31:0] FETCH_ADDR,
  output logic [31:0] CSW_OUT,
  output logic STATE_FLAG,
  output logic REG_WR_BLOCK,
  output logic BASE_WB_EN,
  output logic ENTRY_BUSY
);
  ceu_state_t state_reg;
  ceu_cause_t cause_reg, sel_cause;
  logic [1:0] cnt_reg;
  logic [31:0] csw_reg, lv_reg, sav_reg, wr_link, wr_sav;
  logic [31:0] link_mem [0:4];
  logic [31:0] saved_mem [0:4];
  logic fs1_reg, fs2_reg, fd_reg, ns1_reg, ns2_reg, nd_reg;
  logic fast_lvl, normal_lvl, fiq_ok, irq_ok;
  logic dabort_reg, fabt_reg, chain_reg, rst_seen_reg;
  logic [1:0] tag_reg;
  logic take, commit, rst_rel, wr_bank, wb_go, wb_wr;
  logic dabort_ev, fabt_ev, priv;
  logic [2:0] bank_sel, cur_bank;

  // Mode entered for each cause
  function automatic logic [4:0] mode_of(input ceu_cause_t c);
    case (c)
      CEU_EX_FIQ: mode_of = `CEU_MODE_FIQ;
      CEU_EX_IRQ: mode_of = `CEU_MODE_IRQ;
      CEU_EX_DABORT, CEU_EX_PABORT: mode_of = `CEU_MODE_ABT;
      CEU_EX_UND: mode_of = `CEU_MODE_UND;
      default: mode_of = `CEU_MODE_SVC;
    endcase
  endfunction

  // Vector for each cause; reserved slot has no cause
  function automatic logic [31:0] vec_of(input ceu_cause_t c);
    case (c)
      CEU_EX_DABORT: vec_of = `CEU_VEC_DABORT;
      CEU_EX_FIQ: vec_of = `CEU_VEC_FIQ;
      CEU_EX_IRQ: vec_of = `CEU_VEC_IRQ;
      CEU_EX_PABORT: vec_of = `CEU_VEC_PABORT;
      CEU_EX_UND: vec_of = `CEU_VEC_UND;
      CEU_EX_TRAP: vec_of = `CEU_VEC_TRAP;
      default: vec_of = `CEU_VEC_RST; // RULE_24
    endcase
  endfunction

  // Bank slot of a mode, none for user and system
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      `CEU_MODE_FIQ: bank_of = 3'h0;
      `CEU_MODE_IRQ: bank_of = 3'h1;
      `CEU_MODE_SVC: bank_of = 3'h2;
      `CEU_MODE_ABT: bank_of = 3'h3;
      `CEU_MODE_UND: bank_of = 3'h4;
      default: bank_of = `CEU_BANK_NONE;
    endcase
  endfunction

  // Request synchronisers, two stages or one direct stage
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fs1_reg <= 1'b1;
      fs2_reg <= 1'b1;
      fd_reg <= 1'b1;
      ns1_reg <= 1'b1;
      ns2_reg <= 1'b1;
      nd_reg <= 1'b1;
    end else begin
      fs1_reg <= FAST_REQUEST_LOW_IN; // RULE_08
      fs2_reg <= fs1_reg;
      fd_reg <= FAST_REQUEST_LOW_IN; // RULE_23
      ns1_reg <= NORMAL_REQUEST_LOW_IN;
      ns2_reg <= ns1_reg;
      nd_reg <= NORMAL_REQUEST_LOW_IN;
    end
  end

  // Synchronised levels and mask gating
  assign fast_lvl = INTERRUPT_SYNC_SELECT ? fd_reg : fs2_reg; // RULE_23
  assign normal_lvl = INTERRUPT_SYNC_SELECT ? nd_reg : ns2_reg;
  assign fiq_ok = !fast_lvl && !csw_reg[`CEU_PSR_F]; // RULE_09
  assign irq_ok = !normal_lvl && !csw_reg[`CEU_PSR_I]; // RULE_10

  // Abort events seen only in memory cycles
  assign dabort_ev = ABORT_IN && MEM_CYCLE && MEM_DATA; // RULE_12
  assign fabt_ev = ABORT_IN && MEM_CYCLE && !MEM_DATA;

  // Pending data abort; a new abort beats the clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !RESET_LOW_IN) begin
      dabort_reg <= 1'b0;
    end else if (dabort_ev) begin
      dabort_reg <= 1'b1;
    end else if (take && sel_cause == CEU_EX_DABORT) begin
      dabort_reg <= 1'b0;
    end
  end

  // Prefetch abort tags; a vector load refills the pipe, so tags go
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !RESET_LOW_IN || PIPE_FLUSH || commit) begin
      fabt_reg <= 1'b0;
      tag_reg <= 2'h0;
    end else if (FETCH_ADVANCE) begin
      tag_reg <= {tag_reg[0], fabt_reg | fabt_ev}; // RULE_13
      fabt_reg <= 1'b0;
    end else if (fabt_ev) begin
      fabt_reg <= 1'b1;
    end
  end

  // Write suppression and base write-back after a data abort
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !RESET_LOW_IN) begin
      REG_WR_BLOCK <= 1'b0;
      BASE_WB_EN <= 1'b1;
    end else if (dabort_ev) begin
      REG_WR_BLOCK <= 1'b1; // RULE_15
      unique case (XFER_KIND)
        CEU_XF_SWAP: BASE_WB_EN <= 1'b0; // RULE_14
        CEU_XF_BLOCK: BASE_WB_EN <= XFER_WB; // RULE_15
        default: BASE_WB_EN <= 1'b1; // RULE_14
      endcase
    end else if (INSN_END) begin
      REG_WR_BLOCK <= 1'b0;
      BASE_WB_EN <= 1'b1;
    end
  end

  // Fixed priority pick among pending exceptions
  always_comb begin
    sel_cause = CEU_EX_TRAP; // RULE_17
    if (chain_reg || dabort_reg) begin
      sel_cause = chain_reg ? CEU_EX_FIQ : CEU_EX_DABORT; // RULE_18
    end else if (fiq_ok) begin
      sel_cause = CEU_EX_FIQ;
    end else if (irq_ok) begin
      sel_cause = CEU_EX_IRQ;
    end else if (tag_reg[1]) begin
      sel_cause = CEU_EX_PABORT; // RULE_13
    end else if (INSN_UNDEF) begin
      sel_cause = CEU_EX_UND;
    end
  end

  // Entry starts at instruction end, or right after an abort entry
  assign take = state_reg == CEU_ST_RUN && RESET_LOW_IN && !rst_seen_reg
    && ((INSN_END && (dabort_reg || fiq_ok || irq_ok || tag_reg[1]
    || INSN_UNDEF || INSN_TRAP)) || (chain_reg && fiq_ok)); // RULE_09
  assign commit = state_reg == CEU_ST_ENTRY && cnt_reg == 2'h0;
  assign rst_rel = RESET_LOW_IN && rst_seen_reg; // RULE_21

  // Entry sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !RESET_LOW_IN) begin
      state_reg <= CEU_ST_RUN;
      cause_reg <= CEU_EX_RST;
      cnt_reg <= 2'h0;
      lv_reg <= 32'h0000_0000;
      sav_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        CEU_ST_RUN: begin
          if (take) begin
            state_reg <= CEU_ST_ENTRY;
            cause_reg <= sel_cause;
            sav_reg <= csw_reg; // RULE_02
            unique case (sel_cause)
              CEU_EX_DABORT: cnt_reg <= `CEU_T_EXC_CYC - 2'h1; // RULE_19
              CEU_EX_FIQ: cnt_reg <= `CEU_T_FIQ_CYC - 2'h1; // RULE_19
              default: cnt_reg <= `CEU_T_OTH_CYC - 2'h1;
            endcase
            if (chain_reg) begin
              lv_reg <= `CEU_VEC_DABORT + `CEU_OFS4; // RULE_18
            end else if (sel_cause == CEU_EX_DABORT) begin
              lv_reg <= INSN_PC + `CEU_OFS8; // RULE_06
            end else if (csw_reg[`CEU_PSR_T]
                && (sel_cause == CEU_EX_UND || sel_cause == CEU_EX_TRAP)) begin
              lv_reg <= INSN_PC + `CEU_OFS2;
            end else begin
              lv_reg <= INSN_PC + `CEU_OFS4; // RULE_01
            end
          end
        end
        CEU_ST_ENTRY: begin
          if (commit) begin
            state_reg <= CEU_ST_RUN;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
      endcase
    end
  end

  // Reset tracking and the abort-then-fast chain flag
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !RESET_LOW_IN) begin
      rst_seen_reg <= 1'b1;
      chain_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b0;
      chain_reg <= commit && cause_reg == CEU_EX_DABORT; // RULE_18
    end
  end

  // Bank write data; reset release stores whatever is present
  assign wr_bank = commit || rst_rel;
  assign bank_sel = rst_rel ? 3'h2 : bank_of(mode_of(cause_reg));
  assign wr_link = rst_rel ? INSN_PC : lv_reg; // RULE_07
  assign wr_sav = rst_rel ? csw_reg : sav_reg; // RULE_21

  // Banked link and saved status words, one slot per banked mode
  genvar b;
  generate
    for (b = 0; b < 5; b++) begin : g_bank
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          link_mem[b] <= 32'h0000_0000;
          saved_mem[b] <= 32'h0000_0000;
        end else if (wr_bank && bank_sel == 3'(b)) begin
          link_mem[b] <= wr_link; // RULE_01
          saved_mem[b] <= wr_sav; // RULE_02
        end
      end
    end
  endgenerate

  // Bus decode
  assign cur_bank = bank_of(csw_reg[4:0]);
  assign priv = csw_reg[4:0] != `CEU_MODE_USR;
  assign wb_go = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_go && WB_WE_I;

  // Current status word: reset, entry, exit, software write
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      csw_reg <= `CEU_CSW_RST;
    end else if (rst_rel) begin
      csw_reg[4:0] <= `CEU_MODE_SVC; // RULE_22
      csw_reg[`CEU_PSR_I] <= 1'b1;
      csw_reg[`CEU_PSR_F] <= 1'b1;
      csw_reg[`CEU_PSR_T] <= 1'b0;
    end else if (commit) begin
      csw_reg[4:0] <= mode_of(cause_reg); // RULE_02
      csw_reg[`CEU_PSR_T] <= 1'b0; // RULE_04
      csw_reg[`CEU_PSR_I] <= 1'b1; // RULE_03
      if (cause_reg == CEU_EX_FIQ) begin
        csw_reg[`CEU_PSR_F] <= 1'b1; // RULE_10
      end
    end else if (wb_wr && WB_ADR_I == `CEU_ADR_EXIT
        && cur_bank != `CEU_BANK_NONE) begin
      csw_reg <= saved_mem[cur_bank]; // RULE_05
    end else if (wb_wr && WB_ADR_I == `CEU_ADR_CSW) begin
      if (WB_SEL_I[3]) begin
        csw_reg[31:28] <= WB_DAT_I[31:28];
      end
      if (WB_SEL_I[0] && priv) begin
        csw_reg[7:6] <= WB_DAT_I[7:6]; // RULE_11
        csw_reg[4:0] <= WB_DAT_I[4:0];
      end
    end
  end

  // Vector load, vector address and reset fetch counter
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      VECTOR_ADDR <= `CEU_VEC_RST;
      VECTOR_LOAD <= 1'b0;
      FETCH_ADDR <= `CEU_VEC_RST;
    end else if (!RESET_LOW_IN) begin
      VECTOR_LOAD <= 1'b0;
      FETCH_ADDR <= FETCH_ADDR + `CEU_OFS4; // RULE_20
    end else if (rst_rel) begin
      VECTOR_ADDR <= `CEU_VEC_RST; // RULE_22
      VECTOR_LOAD <= 1'b1;
      FETCH_ADDR <= `CEU_VEC_RST;
    end else begin
      VECTOR_LOAD <= commit;
      if (commit) begin
        VECTOR_ADDR <= vec_of(cause_reg); // RULE_16
        FETCH_ADDR <= vec_of(cause_reg);
      end
    end
  end

  // Mirror of the status word and entry activity
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      CSW_OUT <= `CEU_CSW_RST;
      STATE_FLAG <= 1'b0;
      ENTRY_BUSY <= 1'b0;
    end else begin
      CSW_OUT <= csw_reg;
      STATE_FLAG <= csw_reg[`CEU_PSR_T];
      ENTRY_BUSY <= take || (state_reg == CEU_ST_ENTRY && !commit);
    end
  end

  // Wishbone answer one cycle after the strobe, zero when unmapped
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_go;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_go && !WB_WE_I) begin
        case (WB_ADR_I)
          `CEU_ADR_CSW: WB_DAT_O <= csw_reg;
          `CEU_ADR_SSW: WB_DAT_O <= (cur_bank == `CEU_BANK_NONE)
            ? 32'h0000_0000 : saved_mem[cur_bank];
          `CEU_ADR_LINK: WB_DAT_O <= (cur_bank == `CEU_BANK_NONE)
            ? 32'h0000_0000 : link_mem[cur_bank];
          `CEU_ADR_CAUSE: WB_DAT_O <= {25'h000_0000, cause_reg};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks on entry timing, vectors, masks and reset
  sequence take_fiq_s;
    take && sel_cause == CEU_EX_FIQ;
  endsequence
  sequence abort_commit_s;
    commit && cause_reg == CEU_EX_DABORT && RESET_LOW_IN ##1 fiq_ok;
  endsequence

  fiq_entry_time_a: assert property ( // RULE_19
    @(posedge REF_CLK) disable iff (!RST_N || !RESET_LOW_IN)
    take_fiq_s |-> ##3 (VECTOR_LOAD && VECTOR_ADDR == `CEU_VEC_FIQ))
    else $error("fast entry not two cycles");
  abort_entry_time_a: assert property ( // RULE_19
    @(posedge REF_CLK) disable iff (!RST_N || !RESET_LOW_IN)
    take && sel_cause == CEU_EX_DABORT
    |-> !VECTOR_LOAD[*4] ##1 (VECTOR_LOAD && VECTOR_ADDR == `CEU_VEC_DABORT))
    else $error("abort entry not three cycles");
  abort_then_fiq_a: assert property ( // RULE_18
    @(posedge REF_CLK) disable iff (!RST_N || !RESET_LOW_IN)
    abort_commit_s |-> ##3 (VECTOR_LOAD && VECTOR_ADDR == `CEU_VEC_FIQ))
    else $error("fast entry did not follow abort entry");
  vector_mode_a: assert property ( // RULE_16
    @(posedge REF_CLK) disable iff (!RST_N)
    VECTOR_LOAD && VECTOR_ADDR != `CEU_VEC_RST |-> ##1
    (CSW_OUT[4:0] == mode_of($past(cause_reg))) && VECTOR_ADDR != `CEU_VEC_RSVD)
    else $error("entry mode does not match vector");
  entry_state_a: assert property ( // RULE_04
    @(posedge REF_CLK) disable iff (!RST_N)
    VECTOR_LOAD |=> !STATE_FLAG && CSW_OUT[`CEU_PSR_I])
    else $error("state flag or mask wrong after entry");
  fiq_masks_irq_a: assert property ( // RULE_10
    @(posedge REF_CLK) disable iff (!RST_N || !RESET_LOW_IN)
    commit && cause_reg == CEU_EX_FIQ
    |=> csw_reg[`CEU_PSR_I] && csw_reg[`CEU_PSR_F])
    else $error("fast entry left a mask clear");
  user_mask_a: assert property ( // RULE_11
    @(posedge REF_CLK) disable iff (!RST_N)
    wb_wr && WB_ADR_I == `CEU_ADR_CSW && !priv && !commit && !rst_rel
    |=> csw_reg[7:0] == $past(csw_reg[7:0]))
    else $error("user write changed control bits");
  reset_fetch_a: assert property ( // RULE_20
    @(posedge REF_CLK) disable iff (!RST_N)
    !RESET_LOW_IN |=> FETCH_ADDR == $past(FETCH_ADDR) + `CEU_OFS4)
    else $error("reset fetch did not step a word");
  reset_release_a: assert property ( // RULE_22
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(RESET_LOW_IN) |=> VECTOR_LOAD && VECTOR_ADDR == `CEU_VEC_RST
    && csw_reg[7:0] == 8'hD3)
    else $error("reset release entry wrong");
  abort_block_a: assert property ( // RULE_15
    @(posedge REF_CLK) disable iff (!RST_N || !RESET_LOW_IN)
    dabort_ev && XFER_KIND == CEU_XF_BLOCK |=> REG_WR_BLOCK
    && BASE_WB_EN == $past(XFER_WB))
    else $error("aborted block transfer not guarded");
  sync_delay_a: assert property ( // RULE_08
    @(posedge REF_CLK) disable iff (!RST_N)
    (!INTERRUPT_SYNC_SELECT && !FAST_REQUEST_LOW_IN)[*3] |-> !fast_lvl)
    else $error("synchroniser slower than three cycles");
endmodule
`default_nettype wire

// ---- sim/ceu_far_model.sv ----
// Far-side model: interrupt source and a memory system that aborts.
// Assumes the bench commands it just after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module ceu_far_model (
  input wire logic clk,
  input wire logic want_fast,
  input wire logic want_normal,
  input wire logic do_abort,
  input wire logic abort_data,
  output logic fast_request_low_in = 1'b1,
  output logic normal_request_low_in = 1'b1,
  output logic abort_in = 1'b0,
  output logic mem_cycle = 1'b0,
  output logic mem_data = 1'b0
);
  logic churn_reg = 1'b0;
  // Interrupt requests as active low levels
  always_ff @(posedge clk) begin
    fast_request_low_in <= !want_fast;
    normal_request_low_in <= !want_normal;
  end
  // One memory cycle per abort; abort and kind lines churn outside it
  always_ff @(posedge clk) begin
    churn_reg <= !churn_reg;
    mem_cycle <= do_abort;
    mem_data <= do_abort ? abort_data : churn_reg;
    abort_in <= do_abort | churn_reg;
  end
endmodule
`default_nettype wire

// ---- sim/cpu_exception_unit_bench.sv ----
// Bench of the exception unit: bus tasks, entry sequences and checks.
// Assumes the far-side model and a 250 MHz processor clock.
`timescale 1ns/1ps
`default_nettype none
`include "ceu_consts.svh"
module cpu_exception_unit_bench;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000, rdat, vaddr, faddr, csw, rd, a;
  logic [31:0] pc = 32'h0000_0000;
  logic rst_low = 1'b0, sync_sel = 1'b1, adv = 1'b0, flush = 1'b0, iend = 1'b0;
  logic und = 1'b0, trap = 1'b0, xwb = 1'b0, vload, sflag, rblk, bwb, busy;
  logic [2:0] xkind = 3'h1;
  logic w_fast = 1'b0, w_norm = 1'b0, w_abt = 1'b0, w_dat = 1'b0;
  logic n_fast, n_norm, abt, mcyc, mdat;
  int bad_count = 0, num_checks = 0, cycles = 0, n;
  logic [31:0] vtab [5] = '{`CEU_VEC_IRQ, `CEU_VEC_UND, `CEU_VEC_TRAP,
    `CEU_VEC_PABORT, `CEU_VEC_DABORT};
  logic [31:0] ctab [5] = '{32'h0000_0092, 32'h0000_009B, 32'h0000_0093,
    32'h0000_0097, 32'h0000_0097};

  ceu_exception_unit u_dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .RESET_LOW_IN(rst_low),
    .FAST_REQUEST_LOW_IN(n_fast), .NORMAL_REQUEST_LOW_IN(n_norm),
    .INTERRUPT_SYNC_SELECT(sync_sel), .ABORT_IN(abt), .MEM_CYCLE(mcyc),
    .MEM_DATA(mdat), .FETCH_ADVANCE(adv), .PIPE_FLUSH(flush), .INSN_END(iend),
    .INSN_PC(pc), .INSN_UNDEF(und), .INSN_TRAP(trap), .XFER_KIND(xkind),
    .XFER_WB(xwb), .VECTOR_ADDR(vaddr), .VECTOR_LOAD(vload), .FETCH_ADDR(faddr),
    .CSW_OUT(csw), .STATE_FLAG(sflag), .REG_WR_BLOCK(rblk), .BASE_WB_EN(bwb),
    .ENTRY_BUSY(busy));
  ceu_far_model u_far (.clk(clk), .want_fast(w_fast), .want_normal(w_norm),
    .do_abort(w_abt), .abort_data(w_dat), .fast_request_low_in(n_fast),
    .normal_request_low_in(n_norm), .abort_in(abt), .mem_cycle(mcyc),
    .mem_data(mdat));

  // Clock
  initial begin
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // Classic single bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t >= 20) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic rdchk(input string s, input logic [7:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 32'h0000_0000);
    chk(s, e, rd);
  endtask

  task automatic insn(input logic [31:0] ad, input logic u, input logic s);
    @(posedge clk);
    pc <= ad;
    und <= u;
    trap <= s;
    iend <= 1'b1;
    @(posedge clk);
    iend <= 1'b0;
  endtask

  // Waits for a vector load; latency counted from the taking edge
  task automatic vec(input logic [31:0] v, input logic [31:0] c, input int lat);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1 && lat > 0) chk("entry busy", 32'h0000_0001, busy);
    end while (vload !== 1'b1 && n < 8);
    if (lat > 0) chk("entry latency", lat, n);
    chk("vector", v, vaddr);
    chk("fetch vector", v, faddr);
    @(posedge clk);
    #1;
    chk("status", c, csw);
  endtask

  task automatic abort(input logic d);
    @(posedge clk);
    w_dat <= d;
    w_abt <= 1'b1;
    @(posedge clk);
    w_abt <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd = faddr;
    @(posedge clk);
    #1;
    chk("fetch step", rd + 32'h0000_0004, faddr);
    @(posedge clk);
    rst_low <= 1'b1;
    vec(`CEU_VEC_RST, `CEU_CSW_RST, 0);
    chk("state flag", 32'h0000_0000, sflag);
    rdchk("reset status", 8'h00, `CEU_CSW_RST);
    wb(1'b1, 8'h00, 32'h0000_0013);
    $display("test reset done");
    sync_sel <= 1'b0;
    w_fast <= 1'b1;
    repeat (4) @(posedge clk);
    insn(32'h0000_0100, 1'b0, 1'b0);
    vec(`CEU_VEC_FIQ, 32'h0000_00D1, 2);
    @(posedge clk);
    w_fast <= 1'b0;
    rdchk("fast link", 8'h08, 32'h0000_0104);
    rdchk("fast saved", 8'h04, 32'h0000_0013);
    wb(1'b1, 8'h0C, 32'h0000_0000);
    rdchk("fast exit", 8'h00, 32'h0000_0013);
    $display("test fast done");
    sync_sel <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      a = 32'h0000_0200 + 32'(k * 16);
      w_norm <= (k == 0);
      xkind <= 3'h4;
      xwb <= 1'b1;
      if (k == 3) begin
        abort(1'b0);
        @(posedge clk);
        adv <= 1'b1;
        repeat (2) @(posedge clk);
        adv <= 1'b0;
      end
      if (k == 4) begin
        abort(1'b1);
        chk("base writeback", 32'h0000_0001, bwb);
        chk("write block", 32'h0000_0001, rblk);
      end
      repeat (3) @(posedge clk);
      insn(a, k == 1, k == 2);
      vec(vtab[k], ctab[k], (k == 4) ? 3 : 2);
      rdchk("link", 8'h08, a + ((k == 4) ? 32'h0000_0008 : 32'h0000_0004));
      rdchk("saved", 8'h04, 32'h0000_0013);
      w_norm <= 1'b0;
      wb(1'b1, 8'h0C, 32'h0000_0000);
      rdchk("exit status", 8'h00, 32'h0000_0013);
      $display("test entry %0d done", k);
    end
    w_fast <= 1'b1;
    xkind <= 3'h2;
    abort(1'b1);
    chk("swap writeback", 32'h0000_0000, bwb);
    insn(32'h0000_0300, 1'b0, 1'b0);
    vec(`CEU_VEC_DABORT, 32'h0000_0097, 3);
    vec(`CEU_VEC_FIQ, 32'h0000_00D1, 0);
    rdchk("chained saved", 8'h04, 32'h0000_0097);
    w_fast <= 1'b0;
    wb(1'b1, 8'h0C, 32'h0000_0000);
    rdchk("abort resumes", 8'h00, 32'h0000_0097);
    wb(1'b1, 8'h0C, 32'h0000_0000);
    rdchk("abort exit", 8'h00, 32'h0000_0013);
    $display("test chained done");
    wb(1'b1, 8'h00, 32'h0000_0010);
    wb(1'b1, 8'h00, 32'h0000_00D0);
    rdchk("user masks", 8'h00, 32'h0000_0010);
    abort(1'b0);
    @(posedge clk);
    adv <= 1'b1;
    repeat (2) @(posedge clk);
    adv <= 1'b0;
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    insn(32'h0000_0400, 1'b0, 1'b1);
    vec(`CEU_VEC_TRAP, 32'h0000_0093, 2);
    $display("test user done");
    conclude();
  end
endmodule
`default_nettype wire
